// ===== rtl/sdcfg_pkg.sv
package sdcfg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_STATUS  = 8'h00;
    localparam logic [7:0]  OFS_DCMD    = 8'h08;
    localparam logic [7:0]  OFS_CFG     = 8'h0C;
    localparam logic [31:0] CFG_RESET   = 32'h0001_0020;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    localparam logic [1:0] ST_CONFIG  = 2'h0;
    localparam logic [1:0] ST_READY   = 2'h1;
    localparam logic [1:0] ST_PAUSED  = 2'h2;
    localparam logic [1:0] ST_LOWPWR  = 2'h3;

    // ------------------------------------------------------------
    // Direct command codes
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_PREALL  = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_MODE    = 3'h2;
    localparam logic [2:0] CMD_NOP     = 3'h3;
    localparam logic [2:0] CMD_DPD     = 3'h4;

    // ------------------------------------------------------------
    // Decode constants
    // ------------------------------------------------------------
    localparam logic [4:0] ROW_BASE    = 5'h0B;
    localparam logic [3:0] COL_BASE    = 4'h8;
    localparam logic [3:0] AP_LOW      = 4'h8;
    localparam logic [3:0] AP_HIGH     = 4'hA;
    localparam logic [4:0] BURST_ONE   = 5'h01;
    localparam int         PREALL_BIT  = 10;
    localparam int         NUM_CHIPS   = 4;
    localparam logic [6:0] DLY_ZERO    = 7'h00;
    localparam logic [6:0] DLY_ONE     = 7'h01;

    typedef enum logic [1:0] {
        SDC_S_READY = 2'b01,
        SDC_S_DELAY = 2'b10
    } sdcfg_state_t;

    typedef struct packed {
        logic       auto_self_refresh_entry;
        logic [6:0] forced_precharge_timeout;
        logic       forced_precharge_on;
        logic [1:0] active_chips;
        logic [2:0] qos_sel;
        logic [2:0] burst_code;
        logic       stop_clk;
        logic       auto_pd;
        logic [5:0] pd_period;
        logic       auto_precharge_position;
        logic [2:0] row_code;
        logic [2:0] col_code;
    } sdcfg_cfg_t;

    typedef struct packed {
        logic [8:0]  rsvd_hi;
        logic        cmd_ext;
        logic [1:0]  chip;
        logic [1:0]  cmd_lo;
        logic [1:0]  bank;
        logic [1:0]  rsvd_lo;
        logic [13:0] mode_address_field;
    } sdcfg_dcmd_t;

    typedef struct packed {
        logic [3:0]  cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [13:0] addr;
    } sdcfg_mem_t;

    localparam sdcfg_mem_t MEM_IDLE = '{cs_n: 4'hF, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                        ba: 2'h0, addr: 14'h0000};

endpackage

// ===== rtl/sdcfg_top.sv
`timescale 1ns/100ps
module sdcfg_top
(
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  reset_i,
    input  wire logic                  ce_i,
    // Register port
    input  wire logic [7:0]            addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [31:0]                rdata_o,
    // Controller side
    input  wire logic [1:0]            ctrl_state_i,
    input  wire logic [1:0]            chips_i,
    input  wire logic                  access_i,
    input  wire logic                  fifo_empty_i,
    input  wire logic [6:0]            tmrd_i,
    input  wire logic [4:0]            trfc_i,
    input  wire logic [2:0]            trp_i,
    input  wire logic [7:0]            arid_i,
    // Memory side
    output sdcfg_pkg::sdcfg_mem_t      mem_o,
    output logic                       cke_o,
    output logic                       mem_clk_en_o,
    // Configuration outputs
    output logic [3:0]                 qos_o,
    output logic [4:0]                 burst_len_o,
    output logic [4:0]                 row_bits_o,
    output logic [3:0]                 col_bits_o,
    output logic [3:0]                 ap_line_o,
    output logic [1:0]                 refresh_chips_o,
    output logic                       self_refresh_req_o,
    output logic                       force_precharge_o,
    output logic                       cmd_busy_o
);

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    sdcfg_pkg::sdcfg_cfg_t   cfg_r;
    sdcfg_pkg::sdcfg_dcmd_t  pend_r;
    sdcfg_pkg::sdcfg_dcmd_t  wcmd;
    sdcfg_pkg::sdcfg_mem_t   mem_r;
    sdcfg_pkg::sdcfg_mem_t   mem_nxt;
    sdcfg_pkg::sdcfg_state_t state_r;
    logic                    pend_vld_r;
    logic [6:0]              cnt_r;
    logic [6:0]              load_nxt;
    logic [2:0]              pend_code;
    logic                    wr_ok;
    logic                    dcmd_take;
    logic                    issue;
    logic [3:0]              cs_dec;
    logic                    dpd_r;
    logic                    pd_r;
    logic [5:0]              pd_cnt_r;
    logic [6:0]              idle_cnt_r;
    logic                    fp_r;
    logic                    clk_en_r;
    logic [3:0]              qos_r;
    logic [7:0]              arid_sh;
    logic [31:0]             rdata_r;

    assign wr_ok     = (ctrl_state_i == sdcfg_pkg::ST_CONFIG) ||
                       (ctrl_state_i == sdcfg_pkg::ST_LOWPWR);
    assign wcmd      = sdcfg_pkg::sdcfg_dcmd_t'(wdata_i);
    // A write arriving while a command still waits is dropped; no stall is possible on this port
    assign dcmd_take = ce_i && wr_i && (addr_i == sdcfg_pkg::OFS_DCMD) && wr_ok && !pend_vld_r;
    assign pend_code = {pend_r.cmd_ext, pend_r.cmd_lo};
    assign issue     = ce_i && pend_vld_r && (state_r == sdcfg_pkg::SDC_S_READY);

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            cfg_r <= sdcfg_pkg::sdcfg_cfg_t'(sdcfg_pkg::CFG_RESET);
        else if (ce_i && wr_i && (addr_i == sdcfg_pkg::OFS_CFG) && wr_ok)
            cfg_r <= sdcfg_pkg::sdcfg_cfg_t'(wdata_i);
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            rdata_r <= sdcfg_pkg::RD_ZERO;
        else if (ce_i)
        begin
            rdata_r <= sdcfg_pkg::RD_ZERO;
            if (rd_i && addr_i == sdcfg_pkg::OFS_CFG && wr_ok)
                rdata_r <= 32'(cfg_r);
            else if (rd_i && addr_i == sdcfg_pkg::OFS_STATUS)
                rdata_r <= {27'h0000000, chips_i, pend_vld_r, ctrl_state_i};
        end
    end
    assign rdata_o = rdata_r;

    // ------------------------------------------------------------
    // Pending direct command
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            pend_vld_r <= 1'b0;
            pend_r     <= '0;
        end
        else if (dcmd_take)
        begin
            pend_vld_r <= 1'b1;
            pend_r     <= wcmd;
        end
        else if (issue)
            pend_vld_r <= 1'b0;
    end
    assign cmd_busy_o = pend_vld_r;

    // ------------------------------------------------------------
    // Command spacing
    // ------------------------------------------------------------
    always_comb
    begin
        case (pend_code)
            sdcfg_pkg::CMD_PREALL:  load_nxt = 7'(trp_i);
            sdcfg_pkg::CMD_REFRESH: load_nxt = 7'(trfc_i);
            sdcfg_pkg::CMD_MODE:    load_nxt = tmrd_i;
            default:                load_nxt = sdcfg_pkg::DLY_ONE;
        endcase
        // Counter holds cycles still to wait after the issue cycle
        if (load_nxt != sdcfg_pkg::DLY_ZERO)
            load_nxt = load_nxt - sdcfg_pkg::DLY_ONE;
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            state_r <= sdcfg_pkg::SDC_S_READY;
            cnt_r   <= sdcfg_pkg::DLY_ZERO;
        end
        else if (ce_i)
        begin
            case (state_r)
                sdcfg_pkg::SDC_S_READY:
                begin
                    if (issue && load_nxt != sdcfg_pkg::DLY_ZERO)
                    begin
                        state_r <= sdcfg_pkg::SDC_S_DELAY;
                        cnt_r   <= load_nxt;
                    end
                end
                sdcfg_pkg::SDC_S_DELAY:
                begin
                    cnt_r <= cnt_r - sdcfg_pkg::DLY_ONE;
                    if (cnt_r == sdcfg_pkg::DLY_ONE)
                        state_r <= sdcfg_pkg::SDC_S_READY;
                end
                default:
                begin
                    state_r <= sdcfg_pkg::SDC_S_READY;
                    cnt_r   <= sdcfg_pkg::DLY_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Memory command pins
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < sdcfg_pkg::NUM_CHIPS; gi++)
        begin : g_cs
            assign cs_dec[gi] = (pend_r.chip != 2'(gi));
        end
    endgenerate

    always_comb
    begin
        mem_nxt      = sdcfg_pkg::MEM_IDLE;
        mem_nxt.cs_n = cs_dec;
        case (pend_code)
            sdcfg_pkg::CMD_PREALL:
            begin
                mem_nxt.ras_n = 1'b0;
                mem_nxt.we_n  = 1'b0;
                mem_nxt.addr[sdcfg_pkg::PREALL_BIT] = 1'b1;
            end
            sdcfg_pkg::CMD_REFRESH:
            begin
                mem_nxt.ras_n = 1'b0;
                mem_nxt.cas_n = 1'b0;
            end
            sdcfg_pkg::CMD_MODE:
            begin
                mem_nxt.ras_n = 1'b0;
                mem_nxt.cas_n = 1'b0;
                mem_nxt.we_n  = 1'b0;
                mem_nxt.ba    = pend_r.bank;
                mem_nxt.addr  = pend_r.mode_address_field;
            end
            sdcfg_pkg::CMD_DPD:
                mem_nxt.we_n  = 1'b0;
            default:
                mem_nxt.cs_n  = cs_dec;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            mem_r <= sdcfg_pkg::MEM_IDLE;
        else if (ce_i)
            mem_r <= issue ? mem_nxt : sdcfg_pkg::MEM_IDLE;
    end
    assign mem_o = mem_r;

    // ------------------------------------------------------------
    // Clock enable, deep and automatic power-down
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            dpd_r <= 1'b0;
        else if (issue)
            dpd_r <= (pend_code == sdcfg_pkg::CMD_DPD);
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            pd_cnt_r <= 6'h00;
            pd_r     <= 1'b0;
        end
        else if (ce_i)
        begin
            // A waiting direct command wakes the memory so it can be issued
            if (!cfg_r.auto_pd || !fifo_empty_i || pend_vld_r)
            begin
                pd_cnt_r <= 6'h00;
                pd_r     <= 1'b0;
            end
            else if (pd_cnt_r == cfg_r.pd_period)
                pd_r     <= 1'b1;
            else
                pd_cnt_r <= pd_cnt_r + 6'h01;
        end
    end
    assign cke_o = !dpd_r && !pd_r;

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            clk_en_r <= 1'b1;
        else if (ce_i)
            clk_en_r <= !(cfg_r.stop_clk && !access_i && !pend_vld_r);
    end
    assign mem_clk_en_o = clk_en_r;

    // ------------------------------------------------------------
    // Forced precharge timeout
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            idle_cnt_r <= 7'h00;
            fp_r       <= 1'b0;
        end
        else if (ce_i)
        begin
            fp_r <= 1'b0;
            if (!cfg_r.forced_precharge_on || access_i)
                idle_cnt_r <= 7'h00;
            else if (idle_cnt_r == cfg_r.forced_precharge_timeout)
            begin
                fp_r       <= 1'b1;
                idle_cnt_r <= 7'h00;
            end
            else
                idle_cnt_r <= idle_cnt_r + 7'h01;
        end
    end
    assign force_precharge_o = fp_r;

    // ------------------------------------------------------------
    // Field decodes for the data path
    // ------------------------------------------------------------
    assign arid_sh = arid_i >> cfg_r.qos_sel;

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            qos_r <= 4'h0;
        else if (ce_i)
            qos_r <= arid_sh[3:0];
    end
    assign qos_o = qos_r;

    assign burst_len_o        = sdcfg_pkg::BURST_ONE << cfg_r.burst_code;
    assign row_bits_o         = sdcfg_pkg::ROW_BASE + 5'(cfg_r.row_code);
    assign col_bits_o         = sdcfg_pkg::COL_BASE + 4'(cfg_r.col_code);
    assign ap_line_o          = cfg_r.auto_precharge_position ? sdcfg_pkg::AP_LOW
                                                              : sdcfg_pkg::AP_HIGH;
    // Clamped rather than rejected so a wrong count never targets an absent chip
    assign refresh_chips_o    = (cfg_r.active_chips > chips_i) ? chips_i : cfg_r.active_chips;
    assign self_refresh_req_o = cfg_r.auto_self_refresh_entry;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_DCMD_GATED: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && wr_i && addr_i == sdcfg_pkg::OFS_DCMD && !wr_ok && !pend_vld_r) |=> !pend_vld_r)
        else $error("direct command taken outside config or low power");

    AST_CFG_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && addr_i == sdcfg_pkg::OFS_CFG && !wr_ok) |=> $stable(cfg_r))
        else $error("configuration changed by a refused write");

    AST_CFG_RESET: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(reset_i) |-> (32'(cfg_r) == sdcfg_pkg::CFG_RESET))
        else $error("configuration reset value wrong");

    AST_MODE_PINS: assert property (@(posedge mclk_i) disable iff (reset_i)
        (issue && pend_code == sdcfg_pkg::CMD_MODE) |=>
        (mem_o.ba == $past(pend_r.bank) && mem_o.addr == $past(pend_r.mode_address_field)
         && !mem_o.ras_n && !mem_o.cas_n && !mem_o.we_n))
        else $error("mode access pins wrong");

    AST_CHIP_SEL: assert property (@(posedge mclk_i) disable iff (reset_i)
        issue |=> (!mem_o.cs_n[$past(pend_r.chip)] && $countones(mem_o.cs_n) == 3))
        else $error("wrong chip selected");

    AST_SPACING: assert property (@(posedge mclk_i) disable iff (reset_i)
        (issue && pend_code == sdcfg_pkg::CMD_MODE && tmrd_i >= 7'h03) |=> !issue [*2])
        else $error("command issued before its delay");

    AST_CKE_DROP: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(cke_o) |-> (dpd_r || (cfg_r.auto_pd && $past(pd_cnt_r) == cfg_r.pd_period)))
        else $error("clock enable dropped without cause");

    AST_FORCE_PRE: assert property (@(posedge mclk_i) disable iff (reset_i)
        force_precharge_o |-> ($past(cfg_r.forced_precharge_on) && !$past(access_i)
        && $past(idle_cnt_r) == $past(cfg_r.forced_precharge_timeout)))
        else $error("forced precharge without timeout");

    AST_CLK_STOP: assert property (@(posedge mclk_i) disable iff (reset_i)
        (ce_i && cfg_r.stop_clk && !access_i && !pend_vld_r) |=> !mem_clk_en_o)
        else $error("memory clock not stopped while idle");

endmodule

// ===== dv/sdcfg_sdram_model.sv
`timescale 1ns/100ps
module sdcfg_sdram_model
(
    // Clock
    input  wire logic                  mclk_i,
    // Memory pins
    input  wire sdcfg_pkg::sdcfg_mem_t mem_i,
    input  wire logic                  cke_i,
    // Observed mode register contents
    output logic [13:0]                mode_reg_o,
    output logic [1:0]                 mode_bank_o
);
    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // A device in power-down ignores the bus, so a late CKE hides the write
    always @(posedge mclk_i)
    begin
        if (cke_i && mem_i.cs_n != 4'hF && {mem_i.ras_n, mem_i.cas_n, mem_i.we_n} == 3'h0)
        begin
            mode_reg_o <= mem_i.addr;
            mode_bank_o <= mem_i.ba;
        end
    end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
    logic mclk_i = 1'b0;
    logic reset_i, ce_i, wr_i, rd_i, access_i, fifo_empty_i, rd_d, watch;
    logic [7:0]  addr_i, arid_i;
    logic [31:0] wdata_i, rdata_o, e32;
    logic [1:0]  ctrl_state_i, chips_i, refresh_chips_o, mbank;
    logic [6:0]  tmrd_i;
    logic [4:0]  trfc_i, burst_len_o, row_bits_o;
    logic [2:0]  trp_i;
    logic [3:0]  qos_o, col_bits_o, ap_line_o;
    logic [13:0] mreg;
    logic [15:0] last_mode;
    logic        cke_o, mem_clk_en_o, self_refresh_req_o, force_precharge_o, cmd_busy_o;
    sdcfg_pkg::sdcfg_mem_t mem_o, em;
    sdcfg_pkg::sdcfg_mem_t cq[$];
    logic [31:0] rq[$];
    int          failures = 0;
    int          checks = 0;
    int          cyc = 0;
    int          last_cyc = 0;
    int          min_gap = 1;
    int          gap;

    always #5 mclk_i = ~mclk_i;

    sdcfg_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ctrl_state_i(ctrl_state_i), .chips_i(chips_i),
        .access_i(access_i), .fifo_empty_i(fifo_empty_i), .tmrd_i(tmrd_i), .trfc_i(trfc_i), .trp_i(trp_i),
        .arid_i(arid_i), .mem_o(mem_o), .cke_o(cke_o), .mem_clk_en_o(mem_clk_en_o), .qos_o(qos_o),
        .burst_len_o(burst_len_o), .row_bits_o(row_bits_o), .col_bits_o(col_bits_o), .ap_line_o(ap_line_o),
        .refresh_chips_o(refresh_chips_o), .self_refresh_req_o(self_refresh_req_o),
        .force_precharge_o(force_precharge_o), .cmd_busy_o(cmd_busy_o));

    sdcfg_sdram_model mem_u (.mclk_i(mclk_i), .mem_i(mem_o), .cke_i(cke_o), .mode_reg_o(mreg),
        .mode_bank_o(mbank));

    // ------------------------------------------------------------
    // Closing and bus tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
    endtask

    // Waiting for busy to fall is the only spacing software adds
    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge mclk_i);
        while (cmd_busy_o !== 1'b0 && n < 60)
        begin
            @(negedge mclk_i);
            n++;
        end
        `CHK(cmd_busy_o, 1'b0)
        @(posedge mclk_i);
    endtask

    function automatic int spacing(input sdcfg_pkg::sdcfg_mem_t m);
        int d;
        case ({m.ras_n, m.cas_n, m.we_n})
            3'h2:    d = trp_i;
            3'h1:    d = trfc_i;
            3'h0:    d = tmrd_i;
            default: d = 1;
        endcase
        return (d < 1) ? 1 : d;
    endfunction

    // ------------------------------------------------------------
    // Output monitor
    // ------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            failures++;
            tally_and_finish();
        end
        rd_d <= rd_i && !reset_i;
        if (rd_d)
        begin
            e32 = (rq.size() > 0) ? rq.pop_front() : 32'hDEAD_BEEF;
            `CHK(rdata_o, e32)
        end
        if (watch && !reset_i && mem_o.cs_n !== 4'hF)
        begin
            em = (cq.size() > 0) ? cq.pop_front() : sdcfg_pkg::MEM_IDLE;
            `CHK({mem_o.cs_n, mem_o.ras_n, mem_o.cas_n, mem_o.we_n}, {em.cs_n, em.ras_n, em.cas_n, em.we_n})
            if ({em.ras_n, em.cas_n, em.we_n} == 3'h0)
                `CHK({mem_o.ba, mem_o.addr}, {em.ba, em.addr})
            if ({em.ras_n, em.cas_n, em.we_n} == 3'h2)
                `CHK(mem_o.addr[10], 1'b1)
            if ({em.ras_n, em.cas_n, em.we_n} == 3'h6)
                `CHK(cke_o, 1'b0)
            gap = cyc - last_cyc;
            if (last_cyc != 0)
                `CHK(gap >= min_gap && gap <= min_gap + 5, 1'b1)
            last_cyc = cyc;
            min_gap = spacing(em);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sdcfg_pkg::sdcfg_dcmd_t dc;
        sdcfg_pkg::sdcfg_mem_t  m;
        sdcfg_pkg::sdcfg_cfg_t  c;
        logic [7:0] sh;
        logic [2:0] code;
        int n;
        reset_i = 1'b1;
        ce_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        access_i = 1'b0;
        fifo_empty_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        ctrl_state_i = 2'h0;
        chips_i = 2'h3;
        arid_i = 8'h00;
        tmrd_i = 7'h02;
        trfc_i = 5'h02;
        trp_i = 3'h2;
        watch = 1'b1;
        void'($urandom(32'h3e1251e4));
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        tmrd_i <= 7'($urandom_range(6, 3));
        trfc_i <= 5'($urandom_range(6, 1));
        trp_i <= 3'($urandom_range(6, 1));
        rd(sdcfg_pkg::OFS_CFG, 32'h0001_0020);
        rd(sdcfg_pkg::OFS_DCMD, 32'h0);
        rd(8'h44, 32'h0);
        // Writes outside config and low power leave no trace
        for (int s = 1; s < 3; s++)
        begin
            ctrl_state_i <= 2'(s);
            wr(sdcfg_pkg::OFS_CFG, $urandom);
            wr(sdcfg_pkg::OFS_DCMD, 32'h000C_0000);
            rd(sdcfg_pkg::OFS_CFG, 32'h0);
            rd(sdcfg_pkg::OFS_STATUS, {27'h0, chips_i, 1'b0, 2'(s)});
        end
        ctrl_state_i <= sdcfg_pkg::ST_CONFIG;
        rd(sdcfg_pkg::OFS_CFG, 32'h0001_0020);
        // Every command code, alternating config and low-power state
        for (int i = 0; i < 12; i++)
        begin
            code = 3'(i % 5);
            dc = '0;
            dc.cmd_ext = code[2];
            dc.cmd_lo = code[1:0];
            dc.chip = 2'($urandom);
            dc.bank = 2'($urandom);
            dc.mode_address_field = 14'($urandom);
            if (code == 3'h2)
                dc.mode_address_field[2:0] = sdcfg_pkg::CFG_RESET[17:15];
            m = sdcfg_pkg::MEM_IDLE;
            m.cs_n = ~(4'h1 << dc.chip);
            {m.ras_n, m.cas_n, m.we_n} = (code == 3'h0) ? 3'h2 : (code == 3'h1) ? 3'h1 :
                                         (code == 3'h2) ? 3'h0 : (code == 3'h3) ? 3'h7 : 3'h6;
            m.ba = dc.bank;
            m.addr = dc.mode_address_field;
            if (code == 3'h2)
                last_mode = {dc.bank, dc.mode_address_field};
            cq.push_back(m);
            wait_idle();
            ctrl_state_i <= i[0] ? sdcfg_pkg::ST_LOWPWR : sdcfg_pkg::ST_CONFIG;
            wr(sdcfg_pkg::OFS_DCMD, dc);
        end
        n = 0;
        while (cq.size() > 0 && n < 100)
        begin
            @(negedge mclk_i);
            n++;
        end
        `CHK(cq.size(), 0)
        repeat (3) @(negedge mclk_i);
        `CHK({mbank, mreg}, last_mode)
        watch <= 1'b0;
        // Field decode with legal sizes only, so row and column stay in range
        for (int i = 0; i < 8; i++)
        begin
            c = '0;
            c.burst_code = 3'($urandom_range(4, 0));
            c.row_code = 3'($urandom_range(5, 0));
            c.col_code = 3'($urandom_range(4, 0));
            c.qos_sel = 3'($urandom_range(4, 0));
            c.active_chips = 2'($urandom);
            c.auto_precharge_position = 1'($urandom);
            c.auto_self_refresh_entry = 1'($urandom);
            @(posedge mclk_i);
            chips_i <= 2'($urandom);
            arid_i <= 8'($urandom);
            wr(sdcfg_pkg::OFS_CFG, c);
            rd(sdcfg_pkg::OFS_CFG, c);
            repeat (2) @(negedge mclk_i);
            sh = arid_i >> c.qos_sel;
            `CHK(burst_len_o, 5'h01 << c.burst_code)
            `CHK(row_bits_o, 5'h0B + {2'h0, c.row_code})
            `CHK(col_bits_o, 4'h8 + {1'h0, c.col_code})
            `CHK(ap_line_o, c.auto_precharge_position ? 4'h8 : 4'hA)
            `CHK(refresh_chips_o, (c.active_chips > chips_i) ? chips_i : c.active_chips)
            `CHK(self_refresh_req_o, c.auto_self_refresh_entry)
            `CHK(qos_o, sh[3:0])
        end
        // Power-down after the FIFO has been empty for the period
        c = '0;
        c.auto_pd = 1'b1;
        c.pd_period = 6'h03;
        wr(sdcfg_pkg::OFS_CFG, c);
        fifo_empty_i <= 1'b1;
        n = 0;
        while (cke_o === 1'b1 && n < 20)
        begin
            @(negedge mclk_i);
            n++;
        end
        `CHK(n >= 4 && n <= 8, 1'b1)
        @(posedge mclk_i);
        fifo_empty_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        `CHK(cke_o, 1'b1)
        // Forced precharge pulses every timeout plus one idle cycles
        c = '0;
        c.forced_precharge_on = 1'b1;
        c.forced_precharge_timeout = 7'h05;
        wr(sdcfg_pkg::OFS_CFG, c);
        n = 0;
        while (force_precharge_o !== 1'b1 && n < 40)
        begin
            @(negedge mclk_i);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge mclk_i);
            n++;
        end
        while (force_precharge_o !== 1'b1 && n < 40);
        `CHK(n, 6)
        // Memory clock stops only while no access runs
        c = '0;
        c.stop_clk = 1'b1;
        wr(sdcfg_pkg::OFS_CFG, c);
        repeat (3) @(negedge mclk_i);
        `CHK(mem_clk_en_o, 1'b0)
        @(posedge mclk_i);
        access_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        `CHK(mem_clk_en_o, 1'b1)
        // A write with the clock enable low must leave the configuration alone
        @(posedge mclk_i);
        ce_i <= 1'b0;
        wr(sdcfg_pkg::OFS_CFG, 32'h0);
        ce_i <= 1'b1;
        rd(sdcfg_pkg::OFS_CFG, c);
        tally_and_finish();
    end
endmodule
